// ==== hdl/csc_apb_port.sv ====
`timescale 1ns/1ps
`default_nettype none
module csc_apb_port
	import csc_pkg::*;
(
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [ADDR_W-1:0] paddr_i,
	input wire logic [DATA_W-1:0] read_word_i,
	output logic [DATA_W-1:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	output logic wr_stb_o
);
	logic mapped; // address hits a register

	// ----------------------------------------------------------------
	// zero wait state slave
	// ----------------------------------------------------------------
	assign mapped = reg_mapped(paddr_i);
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i && penable_i && !mapped;
	assign wr_stb_o = psel_i && penable_i && pwrite_i && mapped;

	// read word is captured in the setup cycle
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			prdata_o <= '0;
		end else if (psel_i && !penable_i) begin
			prdata_o <= (!pwrite_i && mapped) ? read_word_i : '0;
		end
	end
endmodule
`default_nettype wire

// ==== hdl/csc_pkg.sv ====
package csc_pkg;

	// ----------------------------------------------------------------
	// register bus
	// ----------------------------------------------------------------
	localparam int ADDR_W = 4; // byte address width of the register window
	localparam int DATA_W = 32; // bus data width
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h0; // status_word
	localparam logic [ADDR_W-1:0] ADDR_BADVA = 4'h4; // bad_virtual_address
	localparam logic [ADDR_W-1:0] ADDR_ERRPC = 4'h8; // error_return_pc
	localparam logic [ADDR_W-1:0] ADDR_CONFIG = 4'hc; // processor_configuration

	// ----------------------------------------------------------------
	// status_word layout
	// ----------------------------------------------------------------
	localparam int ST_IE = 0; // interrupt enable
	localparam int ST_EXL = 1; // exception_level
	localparam int ST_ERL = 2; // error_level
	localparam int ST_KSU_LO = 3; // privilege_mode, two bits
	localparam int ST_UX = 5; // user_wide_addr_enable
	localparam int ST_SX = 6; // supervisor_wide_addr_enable
	localparam int ST_KX = 7; // kernel_wide_addr_enable
	localparam int ST_IM_LO = 8; // interrupt_mask, eight bits
	localparam int IM_W = 8; // interrupt source count
	localparam int ST_DE = 16; // error_exception_inhibit
	localparam int ST_CE = 17; // check bits from ecc register
	localparam int ST_CH = 18; // secondary_lookup_hit
	localparam int ST_SR = 20; // soft reset seen
	localparam int ST_TS = 21; // tlb_shutdown_flag
	localparam int ST_BEV = 22; // boot_vector_select
	localparam int ST_RE = 25; // user_byte_swap
	localparam logic [31:0] STATUS_WR_MASK = 32'hfe43_ffff; // sw writable
	localparam logic [31:0] STATUS_HW_MASK = 32'h0034_0000; // hw owned
	localparam logic [31:0] STATUS_RESET = 32'h0040_0004; // bev, erl set

	// privilege_mode encodings
	localparam logic [1:0] KSU_KERNEL = 2'h0;
	localparam logic [1:0] KSU_SUPER = 2'h1;
	localparam logic [1:0] KSU_USER = 2'h2;

	// ----------------------------------------------------------------
	// processor_configuration layout
	// ----------------------------------------------------------------
	localparam int CFG_SW_W = 6; // software bits 5..0
	localparam int CFG_HW_W = 26; // hardware bits 31..6
	localparam int CFG_CU = 3; // store_cond_update
	localparam int CFG_DB = 4; // data_line_size
	localparam int CFG_IB = 5; // instr_line_size
	localparam int CFG_DC_LO = 6; // data_cache_size, three bits
	localparam int CFG_IC_LO = 9; // instr_cache_size, three bits
	localparam logic [CFG_SW_W-1:0] CFG_SW_RESET = 6'h02;
	localparam logic [2:0] K0_UNCACHED = 3'h2;
	localparam logic [2:0] K0_CACHED_NC = 3'h3;
	localparam int CACHE_LOG2_BASE = 12; // smallest primary cache, log2
	localparam logic [5:0] LINE_LONG = 6'h20; // 32 byte lines
	localparam logic [5:0] LINE_SHORT = 6'h10; // 16 byte lines

	// ----------------------------------------------------------------
	// serial rom timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 4; // 250 MHz
	localparam int ROM_HALF_BIT_NS = 80; // least half period of rom clock
	localparam int ROM_DIV = (ROM_HALF_BIT_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;

	typedef enum {LD_SHIFT, LD_DONE} csc_load_state_type;

	// true for the four word addresses of the register window
	function automatic logic reg_mapped(input logic [ADDR_W-1:0] a);
		return a == ADDR_STATUS || a == ADDR_BADVA || a == ADDR_ERRPC
			|| a == ADDR_CONFIG;
	endfunction

endpackage

// ==== hdl/csc_rom_loader.sv ====
`timescale 1ns/1ps
`default_nettype none
module csc_rom_loader
	import csc_pkg::*;
#(
	parameter int HW_BITS = CFG_HW_W,
	parameter int DIV = ROM_DIV
) (
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic rom_data_i,
	output logic rom_clock_o,
	output logic [HW_BITS-1:0] hw_bits_o,
	output logic done_o
);
	localparam int CW = $clog2(DIV + 1);
	localparam int BW = $clog2(HW_BITS + 1);
	logic [CW-1:0] div_reg; // half period divider
	logic tick; // one-cycle enable at each half period
	logic sync1_reg, sync2_reg; // pin synchroniser
	logic [BW-1:0] count_reg; // bits taken so far
	csc_load_state_type state_reg;

	// ----------------------------------------------------------------
	// divider and synchroniser
	// ----------------------------------------------------------------
	assign tick = div_reg == CW'(DIV - 1);
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			div_reg <= '0;
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
		end else begin
			div_reg <= tick ? '0 : div_reg + 1'b1;
			sync1_reg <= rom_data_i;
			sync2_reg <= sync1_reg;
		end
	end

	// ----------------------------------------------------------------
	// shifter: data taken on the falling rom clock edge, msb first
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_reg <= LD_SHIFT;
			rom_clock_o <= 1'b0;
			count_reg <= '0;
			hw_bits_o <= '0;
		end else begin
			case (state_reg)
				LD_SHIFT: begin
					if (tick) begin
						rom_clock_o <= ~rom_clock_o;
						if (rom_clock_o) begin
							hw_bits_o <= {hw_bits_o[HW_BITS-2:0], sync2_reg};
							count_reg <= count_reg + 1'b1;
							if (count_reg == BW'(HW_BITS - 1)) begin
								state_reg <= LD_DONE;
							end
						end
					end
				end
				default: begin
					rom_clock_o <= 1'b0;
				end
			endcase
		end
	end
	assign done_o = state_reg == LD_DONE;
endmodule
`default_nettype wire

// ==== hdl/csc_system_control.sv ====
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - interrupt only when mask and pending agree
// - mode field: 10 user, 01 supervisor, 00 kernel
// - error and exception level bits read state
// - three per-mode 64-bit addressing enables
// - byte swap applies to user mode only
// - bit 22 selects normal or bootstrap vectors
// - bit 21 read-only tlb shutdown flag
// - bit 20 marks last reset as soft
// - bit 18 holds last secondary hit result
// - bit 17 takes check bits from ecc
// - bit 16 suppresses cache error exceptions
// - reserved diagnostic bits written and read zero
// - capture latest faulting virtual address
// - error pc loaded on errors and resets
// - error pc holds faulting or branch address
// - config bits 31..6 hardware set, read-only
// - config bits 5..0 software read/write
// - config bits 31..6 from serial rom
// - cache size is two to twelve plus field
// - line size bit: 32 or 16 bytes
// - store conditional coherency selected by bit
// - unmapped segment: 2 uncached, 3 cached
module csc_system_control
	import csc_pkg::*;
(
	input wire logic clock_i,
	input wire logic reset_n_i,
	// register bus
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [ADDR_W-1:0] paddr_i,
	input wire logic [DATA_W-1:0] pwdata_i,
	output logic [DATA_W-1:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// pipeline events
	input wire logic [IM_W-1:0] interrupt_pending_i,
	input wire logic tlb_shutdown_i,
	input wire logic soft_reset_i,
	input wire logic [31:0] reset_pc_i,
	input wire logic translation_error_i,
	input wire logic [31:0] fault_vaddr_i,
	input wire logic error_exception_i,
	input wire logic [31:0] fault_pc_i,
	input wire logic fault_in_delay_slot_i,
	input wire logic [31:0] branch_pc_i,
	input wire logic cache_hit_op_i,
	input wire logic cache_hit_result_i,
	// serial configuration rom
	input wire logic rom_data_i,
	output logic rom_clock_o,
	output logic config_loaded_o,
	// mode and control outputs
	output logic interrupt_request_o,
	output logic kernel_mode_o,
	output logic supervisor_mode_o,
	output logic user_mode_o,
	output logic wide_addr_o,
	output logic wide_ops_o,
	output logic byte_swap_o,
	output logic boot_vector_select_o,
	output logic check_bits_from_ecc_o,
	output logic error_exception_inhibit_o,
	output logic store_cond_coherent_o,
	output logic unmapped_uncached_o,
	output logic unmapped_cached_noncoherent_o,
	output logic [19:0] instr_cache_bytes_o,
	output logic [19:0] data_cache_bytes_o,
	output logic [5:0] instr_line_bytes_o,
	output logic [5:0] data_line_bytes_o
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [31:0] status_reg; // status_word
	logic [31:0] bad_vaddr_reg; // bad_virtual_address
	logic [31:0] error_pc_reg; // error_return_pc
	logic [CFG_SW_W-1:0] cfg_sw_reg; // configuration bits 5..0
	logic [CFG_HW_W-1:0] cfg_hw; // configuration bits 31..6
	logic [31:0] config_word; // assembled configuration
	logic boot_pending_reg; // first cycle after hard reset release
	logic wr_stb; // bus write takes effect this edge
	logic [DATA_W-1:0] read_word; // word selected by the bus address
	logic [1:0] privilege_mode; // current mode field
	logic [IM_W-1:0] interrupt_mask; // per source enables
	logic exception_level; // exception level bit
	logic error_level; // error level bit
	logic level_raised; // either level forces kernel mode

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// primary cache bytes from a three bit size field
	function automatic logic [19:0] cache_bytes(input logic [2:0] f);
		return 20'h1 << (CACHE_LOG2_BASE + int'(f));
	endfunction

	// ----------------------------------------------------------------
	// bus slave
	// ----------------------------------------------------------------
	csc_apb_port u_port (
		.clock_i(clock_i),
		.reset_n_i(reset_n_i),
		.psel_i(psel_i),
		.penable_i(penable_i),
		.pwrite_i(pwrite_i),
		.paddr_i(paddr_i),
		.read_word_i(read_word),
		.prdata_o(prdata_o),
		.pready_o(pready_o),
		.pslverr_o(pslverr_o),
		.wr_stb_o(wr_stb)
	);

	// read mux over the four registers
	always_comb begin
		case (paddr_i)
			ADDR_STATUS: read_word = status_reg;
			ADDR_BADVA: read_word = bad_vaddr_reg;
			ADDR_ERRPC: read_word = error_pc_reg;
			ADDR_CONFIG: read_word = config_word;
			default: read_word = '0;
		endcase
	end

	// ----------------------------------------------------------------
	// serial rom loader for hardware configuration
	// ----------------------------------------------------------------
	csc_rom_loader u_loader (
		.clock_i(clock_i),
		.reset_n_i(reset_n_i),
		.rom_data_i(rom_data_i),
		.rom_clock_o(rom_clock_o),
		.hw_bits_o(cfg_hw),
		.done_o(config_loaded_o)
	);

	// ----------------------------------------------------------------
	// status word
	// ----------------------------------------------------------------
	// software first, hardware events after so a set beats a clear
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			status_reg <= STATUS_RESET; // sr cleared by hard reset
		end else begin
			if (wr_stb && paddr_i == ADDR_STATUS) begin
				// reserved bits forced low, hw bits kept
				status_reg <= (pwdata_i & STATUS_WR_MASK)
					| (status_reg & STATUS_HW_MASK);
			end
			if (tlb_shutdown_i) begin
				status_reg[ST_TS] <= 1'b1;
			end
			if (cache_hit_op_i) begin
				status_reg[ST_CH] <= cache_hit_result_i;
			end
			if (error_exception_i) begin
				status_reg[ST_ERL] <= 1'b1;
			end
			if (soft_reset_i) begin
				status_reg[ST_SR] <= 1'b1;
				status_reg[ST_ERL] <= 1'b1;
				status_reg[ST_BEV] <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// bad virtual address
	// ----------------------------------------------------------------
	// loaded only by the pipeline; bus writes never reach it
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			bad_vaddr_reg <= '0;
		end else if (translation_error_i) begin
			bad_vaddr_reg <= fault_vaddr_i;
		end
	end

	// ----------------------------------------------------------------
	// error return pc
	// ----------------------------------------------------------------
	// reset pc is caught one edge after hard reset release
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			boot_pending_reg <= 1'b1;
		end else begin
			boot_pending_reg <= 1'b0;
		end
	end

	// reset events beat an error exception, both beat software
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			error_pc_reg <= '0;
		end else if (boot_pending_reg || soft_reset_i) begin
			error_pc_reg <= reset_pc_i;
		end else if (error_exception_i) begin
			// no delay slot flag is kept anywhere
			error_pc_reg <= fault_in_delay_slot_i ? branch_pc_i
				: fault_pc_i;
		end else if (wr_stb && paddr_i == ADDR_ERRPC) begin
			error_pc_reg <= pwdata_i;
		end
	end

	// ----------------------------------------------------------------
	// configuration
	// ----------------------------------------------------------------
	// only the low six bits take bus writes
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cfg_sw_reg <= CFG_SW_RESET;
		end else if (wr_stb && paddr_i == ADDR_CONFIG) begin
			cfg_sw_reg <= pwdata_i[CFG_SW_W-1:0];
		end
	end

	// upper bits come only from the rom shifter
	assign config_word = {cfg_hw, cfg_sw_reg};

	// ----------------------------------------------------------------
	// field decode
	// ----------------------------------------------------------------
	assign privilege_mode = status_reg[ST_KSU_LO+1:ST_KSU_LO];
	assign interrupt_mask = status_reg[ST_IM_LO+IM_W-1:ST_IM_LO];
	assign exception_level = status_reg[ST_EXL];
	assign error_level = status_reg[ST_ERL];
	assign level_raised = exception_level || error_level;

	// masked sources gate the request; raised levels hold it off
	assign interrupt_request_o = status_reg[ST_IE] && !level_raised
		&& |(interrupt_mask & interrupt_pending_i);

	// mode field decode; code 11 falls back to kernel
	assign user_mode_o = !level_raised
		&& privilege_mode == KSU_USER;
	assign supervisor_mode_o = !level_raised
		&& privilege_mode == KSU_SUPER;
	assign kernel_mode_o = !user_mode_o && !supervisor_mode_o;

	// per mode wide addressing; wide operations outside kernel only
	always_comb begin
		wide_addr_o = status_reg[ST_KX];
		wide_ops_o = 1'b0;
		if (user_mode_o) begin
			wide_addr_o = status_reg[ST_UX];
			wide_ops_o = status_reg[ST_UX];
		end else if (supervisor_mode_o) begin
			wide_addr_o = status_reg[ST_SX];
			wide_ops_o = status_reg[ST_SX];
		end
	end

	assign byte_swap_o = status_reg[ST_RE] && user_mode_o;
	assign boot_vector_select_o = status_reg[ST_BEV];
	assign check_bits_from_ecc_o = status_reg[ST_CE];
	assign error_exception_inhibit_o = status_reg[ST_DE];

	// configuration driven controls
	assign store_cond_coherent_o = cfg_sw_reg[CFG_CU];
	assign unmapped_uncached_o = cfg_sw_reg[2:0] == K0_UNCACHED;
	assign unmapped_cached_noncoherent_o
		= cfg_sw_reg[2:0] == K0_CACHED_NC;
	assign instr_cache_bytes_o
		= cache_bytes(config_word[CFG_IC_LO+2:CFG_IC_LO]);
	assign data_cache_bytes_o
		= cache_bytes(config_word[CFG_DC_LO+2:CFG_DC_LO]);
	assign instr_line_bytes_o = config_word[CFG_IB] ? LINE_LONG
		: LINE_SHORT;
	assign data_line_bytes_o = config_word[CFG_DB] ? LINE_LONG
		: LINE_SHORT;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!reset_n_i);

	// an error exception with no competing reset
	sequence s_plain_error;
		error_exception_i && !soft_reset_i && !boot_pending_reg;
	endsequence

	// the error pc value that the exception must leave behind
	sequence s_error_pc_loaded;
		error_pc_reg == $past(fault_in_delay_slot_i ? branch_pc_i
			: fault_pc_i) && error_level;
	endsequence

	a_irq_masked_off: assert property (
		(interrupt_mask & interrupt_pending_i) == '0
		|-> !interrupt_request_o)
		else $error("interrupt raised with no enabled pending source");

	a_mode_one_hot: assert property (
		$onehot({user_mode_o, supervisor_mode_o, kernel_mode_o})
		&& (privilege_mode != KSU_KERNEL || kernel_mode_o))
		else $error("privilege mode decode wrong");

	a_swap_user_only: assert property (
		byte_swap_o |-> user_mode_o && status_reg[ST_RE])
		else $error("byte swap outside user mode");

	a_ts_sticky_set: assert property (
		tlb_shutdown_i || status_reg[ST_TS] |=> status_reg[ST_TS])
		else $error("tlb shutdown flag lost");

	a_soft_reset_marks: assert property (
		soft_reset_i |=> status_reg[ST_SR] && error_level
		&& boot_vector_select_o && error_pc_reg == $past(reset_pc_i))
		else $error("soft reset not recorded");

	a_hit_recorded: assert property (
		cache_hit_op_i ##1 (!cache_hit_op_i)[*2]
		|-> status_reg[ST_CH] == $past(cache_hit_result_i, 2))
		else $error("secondary hit result not held");

	a_reserved_zero: assert property (
		status_reg[24:23] == 2'h0 && !status_reg[19])
		else $error("reserved status bits not zero");

	a_badva_capture: assert property (
		translation_error_i |=> bad_vaddr_reg == $past(fault_vaddr_i))
		else $error("bad virtual address not captured");

	a_errpc_source: assert property (
		s_plain_error |=> s_error_pc_loaded)
		else $error("error pc holds wrong address");

	a_config_hw_ro: assert property (
		config_loaded_o && wr_stb |=> $stable(cfg_hw))
		else $error("hardware configuration bits changed by write");

	a_badva_write_ro: assert property (
		wr_stb && paddr_i == ADDR_BADVA && !translation_error_i
		|=> $stable(bad_vaddr_reg))
		else $error("write reached read-only address register");

endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import csc_pkg::*;
;
	// ----------------------------------------------------------------
	// stimulus and observed signals
	// ----------------------------------------------------------------
	logic clock_i = 0, reset_n_i = 0; // clock and active-low reset
	logic psel_i = 0, penable_i = 0, pwrite_i = 0; // apb controls
	logic [ADDR_W-1:0] paddr_i = '0;
	logic [DATA_W-1:0] pwdata_i = '0, prdata_o;
	logic pready_o, pslverr_o;
	logic [IM_W-1:0] interrupt_pending_i = '0;
	logic tlb_shutdown_i, soft_reset_i, translation_error_i;
	logic error_exception_i, cache_hit_op_i;
	logic fault_in_delay_slot_i = 0, cache_hit_result_i = 0;
	logic [4:0] ev = '0; // event pulses: tlb, hit, soft, xlate, error
	logic [31:0] reset_pc_i = 32'h1fc0_0000, fault_vaddr_i = 32'h0;
	logic [31:0] fault_pc_i = 32'h0, branch_pc_i = 32'h0;
	logic rom_data_i = 1; // rom delivers all ones
	logic rom_clock_o, config_loaded_o, interrupt_request_o;
	logic kernel_mode_o, supervisor_mode_o, user_mode_o, wide_addr_o;
	logic wide_ops_o, byte_swap_o, boot_vector_select_o;
	logic check_bits_from_ecc_o, error_exception_inhibit_o;
	logic store_cond_coherent_o, unmapped_uncached_o;
	logic unmapped_cached_noncoherent_o;
	logic [19:0] instr_cache_bytes_o, data_cache_bytes_o;
	logic [5:0] instr_line_bytes_o, data_line_bytes_o;
	int fails = 0, comparisons = 0;
	logic [31:0] rd; // last read word
	logic err; // last read error flag
	assign {error_exception_i, translation_error_i, soft_reset_i,
		cache_hit_op_i, tlb_shutdown_i} = ev;

	csc_system_control u_csc_system_control (.clock_i, .reset_n_i,
		.psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
		.pready_o, .pslverr_o, .interrupt_pending_i, .tlb_shutdown_i,
		.soft_reset_i, .reset_pc_i, .translation_error_i, .fault_vaddr_i,
		.error_exception_i, .fault_pc_i, .fault_in_delay_slot_i,
		.branch_pc_i, .cache_hit_op_i, .cache_hit_result_i, .rom_data_i,
		.rom_clock_o, .config_loaded_o, .interrupt_request_o,
		.kernel_mode_o, .supervisor_mode_o, .user_mode_o, .wide_addr_o,
		.wide_ops_o, .byte_swap_o, .boot_vector_select_o,
		.check_bits_from_ecc_o, .error_exception_inhibit_o,
		.store_cond_coherent_o, .unmapped_uncached_o,
		.unmapped_cached_noncoherent_o, .instr_cache_bytes_o,
		.data_cache_bytes_o, .instr_line_bytes_o, .data_line_bytes_o);

	// 250 MHz clock
	always #2 clock_i = ~clock_i;

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	// verdict and end of run
	task automatic finish_test();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// compare one value
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
			fails++;
		end
	endtask

	// one apb transfer: setup, access held until pready
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock_i);
		psel_i <= 1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clock_i);
		penable_i <= 1;
		do begin
			@(posedge clock_i);
			n++;
		end while (pready_o !== 1'b1 && n < 50);
		rd = prdata_o;
		err = pslverr_o;
		if (pready_o !== 1'b1) begin
			fails++;
			finish_test();
		end
		psel_i <= 0;
		penable_i <= 0;
		// let a write settle before callers look at decoded outputs
		@(posedge clock_i);
	endtask

	// one-cycle event pulse on bit s of ev
	task automatic pulse(input int s);
		@(posedge clock_i);
		ev <= 5'h01 << s;
		@(posedge clock_i);
		ev <= '0;
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		int n;
		repeat (10) @(posedge clock_i);
		reset_n_i <= 1;
		@(posedge clock_i);
		apb(0, ADDR_STATUS, 0); chk(rd, 32'h0040_0004);
		chk(boot_vector_select_o, 1);
		apb(0, ADDR_ERRPC, 0); chk(rd, 32'h1fc0_0000);
		apb(1, ADDR_STATUS, '1);
		apb(0, ADDR_STATUS, 0); chk(rd, 32'hfe43_ffff);
		chk({check_bits_from_ecc_o, error_exception_inhibit_o}, 3);
		apb(1, ADDR_STATUS, 0);
		chk({boot_vector_select_o, error_exception_inhibit_o}, 0);
		// each mode, with and without its own wide enable
		for (int k = 0; k < 3; k++) begin
			for (int j = 0; j < 2; j++) begin
				apb(1, ADDR_STATUS, 32'h0200_0000 | (k << 3)
					| (j ? (~(32'h80 >> k) & 32'he0) : (32'h80 >> k)));
				chk({kernel_mode_o, supervisor_mode_o, user_mode_o}, 4 >> k);
				chk({wide_addr_o, wide_ops_o}, j ? 0 : {1'b1, k != 0});
				chk(byte_swap_o, k == 2);
			end
		end
		// interrupt needs matching mask and pending bits
		apb(1, ADDR_STATUS, 32'h0000_0101);
		interrupt_pending_i <= 8'hfe;
		@(posedge clock_i);
		@(posedge clock_i); chk(interrupt_request_o, 0);
		interrupt_pending_i <= 8'h01;
		@(posedge clock_i);
		@(posedge clock_i); chk(interrupt_request_o, 1);
		// hardware events
		apb(1, ADDR_STATUS, 0);
		pulse(0);
		apb(1, ADDR_STATUS, 32'h0000_0000);
		apb(0, ADDR_STATUS, 0); chk(rd, 32'h0020_0000);
		cache_hit_result_i <= 1;
		pulse(1);
		apb(0, ADDR_STATUS, 0); chk(rd, 32'h0024_0000);
		reset_pc_i <= 32'h1fc0_0100;
		pulse(2);
		apb(0, ADDR_STATUS, 0); chk(rd & 32'h0070_0004, 32'h0070_0004);
		apb(0, ADDR_ERRPC, 0); chk(rd, 32'h1fc0_0100);
		fault_vaddr_i <= 32'h8765_4320;
		pulse(3);
		apb(1, ADDR_BADVA, '1);
		apb(0, ADDR_BADVA, 0); chk(rd, 32'h8765_4320);
		fault_pc_i <= 32'h0040_0010;
		branch_pc_i <= 32'h0040_000c;
		fault_in_delay_slot_i <= 1;
		pulse(4);
		apb(0, ADDR_ERRPC, 0); chk(rd, 32'h0040_000c);
		fault_in_delay_slot_i <= 0;
		pulse(4);
		apb(0, ADDR_ERRPC, 0); chk(rd, 32'h0040_0010);
		apb(0, 4'h2, 0);
		chk(err, 32'h1);
		chk(rd, 32'h0);
		// configuration after the rom load
		n = 0;
		while (config_loaded_o !== 1'b1 && n < 3000) begin
			@(posedge clock_i);
			n++;
		end
		if (config_loaded_o !== 1'b1) begin
			fails++;
			finish_test();
		end
		chk(rom_clock_o, 32'h0);
		apb(1, ADDR_CONFIG, 32'h0000_001b);
		apb(0, ADDR_CONFIG, 0); chk(rd, 32'hffff_ffdb);
		chk(instr_cache_bytes_o, 32'h0008_0000);
		chk(data_cache_bytes_o, 32'h0008_0000);
		chk({instr_line_bytes_o, data_line_bytes_o}, {6'h10, 6'h20});
		chk(store_cond_coherent_o, 1);
		chk({unmapped_uncached_o, unmapped_cached_noncoherent_o}, 1);
		apb(1, ADDR_CONFIG, 32'h0000_0022);
		apb(0, ADDR_CONFIG, 0); chk(rd, 32'hffff_ffe2);
		chk({unmapped_uncached_o, store_cond_coherent_o}, 2);
		chk(instr_line_bytes_o, 6'h20);
		finish_test();
	end
endmodule
`default_nettype wire
